// ### rtl/hbs_brake_seq.v
/*
  hbs_brake_seq: mechanical brake sequencer for a hoist drive, with register
  port, interrupt and terminal function mapping.
  Assumes run_cmd, out_freq and out_current come from drive logic on clk_sys;
  the confirmation contact is an asynchronous pin.
*/
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "hbs_consts.vh"

// Operation
// - sequence runs only when enable code set
// - on run, ramp only to release frequency
// - at release frequency wait, then release brake
// - current too low after wait: trip
// - confirm allocated: hold, await confirm, timeout trips
// - confirm unallocated: skip confirmation wait
// - wait accel time, then accelerate freely
// - run removed: decelerate to brake-on, engage
// - confirm allocated: await confirm release, timeout trips
// - wait stop time, then decelerate to zero
// - every fault trips, flags error, records code
// - confirm lost while released is fault
// - terminals mapped by function codes 44/19/20
// - release current limited to twice rated
module hbs_brake_seq #(
  parameter [31:0] TICK_CYCLES = `HBS_TICK_CYCLES
) (
  input wire clk_sys,
  input wire resetn,
  input wire [5:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  input wire run_cmd,
  input wire [15:0] out_freq,
  input wire [15:0] out_current,
  input wire brake_confirm_in,
  output reg [15:0] freq_limit_q,
  output reg freq_hold_q,
  output reg trip_q,
  output reg brake_release_out_q,
  output reg brake_error_out_q,
  output reg [1:0] term_out_q,
  output reg irq_q
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ACC_REL = 4'h1;
  localparam [3:0] ST_REL_WAIT = 4'h2;
  localparam [3:0] ST_CONF_ON = 4'h3;
  localparam [3:0] ST_ACC_WAIT = 4'h4;
  localparam [3:0] ST_RUNNING = 4'h5;
  localparam [3:0] ST_DEC_BRK = 4'h6;
  localparam [3:0] ST_CONF_OFF = 4'h7;
  localparam [3:0] ST_STOP_WAIT = 4'h8;
  localparam [3:0] ST_DEC_ZERO = 4'h9;
  localparam [3:0] ST_FAULT = 4'hA;

  // clamp a written value to its documented maximum
  function [15:0] sat16;
    input [31:0] val;
    input [15:0] max;
    begin
      if (val > {16'h0000, max}) begin
        sat16 = max;
      end else begin
        sat16 = val[15:0];
      end
    end
  endfunction

  // what an output terminal shows for its function code
  function term_level;
    input [7:0] code;
    input rel;
    input err;
    begin
      if (code == `HBS_FUNC_RELEASE) begin
        term_level = rel;
      end else if (code == `HBS_FUNC_ERROR) begin
        term_level = err;
      end else begin
        term_level = 1'b0;
      end
    end
  endfunction

  reg [7:0] enable_q;
  reg [15:0] rel_wait_q;
  reg [15:0] acc_wait_q;
  reg [15:0] stop_wait_q;
  reg [15:0] conf_wait_q;
  reg [15:0] rel_freq_q;
  reg [15:0] rel_cur_q;
  reg [15:0] brk_on_freq_q;
  reg [7:0] in_func_q;
  reg [7:0] out0_func_q;
  reg [7:0] out1_func_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg [7:0] err_code_q;
  reg conf_s1_q;
  reg conf_s2_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg release_d;
  reg tmr_start_q;
  reg [15:0] tmr_val_q;
  reg [15:0] tmr_val_d;
  wire tmr_done;
  wire confirm_alloc;
  wire wait_state;
  wire clear_cmd;
  wire [2:0] irq_event;
  wire [2:0] irq_w1c;

  assign confirm_alloc = (in_func_q == `HBS_FUNC_CONFIRM);
  assign clear_cmd = reg_wr && (reg_addr == `HBS_OFS_CMD) && reg_wdata[`HBS_CMD_CLEAR];
  assign wait_state = (state_q == ST_REL_WAIT) || (state_q == ST_CONF_ON) || (state_q == ST_ACC_WAIT) ||
                      (state_q == ST_CONF_OFF) || (state_q == ST_STOP_WAIT);

  // confirmation contact is a pin: two flops before use
  always @(posedge clk_sys) begin
    if (!resetn) begin
      conf_s1_q <= 1'b0;
      conf_s2_q <= 1'b0;
    end else begin
      conf_s1_q <= brake_confirm_in;
      conf_s2_q <= conf_s1_q;
    end
  end

  // shared wait timer; aborted outside wait states so no stale expiry leaks in
  hbs_wait_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(tmr_start_q),
    .abort(!wait_state),
    .load_val(tmr_val_q),
    .done_q(tmr_done)
  );

  // sequence next state; a wait state is only entered together with a timer start
  always @* begin
    state_d = state_q;
    release_d = brake_release_out_q;
    tmr_val_d = tmr_val_q;
    case (state_q)
      ST_IDLE: begin
        release_d = 1'b0;
        if ((enable_q == `HBS_CTRL_ENABLED) && run_cmd) begin
          state_d = ST_ACC_REL;
        end
      end
      ST_ACC_REL: begin
        if (!run_cmd) begin
          state_d = ST_DEC_ZERO;
        end else if (out_freq >= rel_freq_q) begin
          state_d = ST_REL_WAIT;
          tmr_val_d = rel_wait_q;
        end
      end
      ST_REL_WAIT: begin
        if (!run_cmd) begin
          state_d = ST_DEC_ZERO;
        end else if (tmr_done) begin
          if (out_current < rel_cur_q) begin
            state_d = ST_FAULT;
          end else if (confirm_alloc) begin
            release_d = 1'b1;
            state_d = ST_CONF_ON;
            tmr_val_d = conf_wait_q;
          end else begin
            release_d = 1'b1;
            state_d = ST_ACC_WAIT;
            tmr_val_d = acc_wait_q;
          end
        end
      end
      ST_CONF_ON: begin
        if (conf_s2_q) begin
          state_d = ST_ACC_WAIT;
          tmr_val_d = acc_wait_q;
        end else if (tmr_done) begin
          state_d = ST_FAULT;
        end
      end
      ST_ACC_WAIT: begin
        if (confirm_alloc && !conf_s2_q) begin
          state_d = ST_FAULT;
        end else if (tmr_done) begin
          state_d = run_cmd ? ST_RUNNING : ST_DEC_BRK;
        end
      end
      ST_RUNNING: begin
        if (confirm_alloc && !conf_s2_q) begin
          state_d = ST_FAULT;
        end else if (!run_cmd) begin
          state_d = ST_DEC_BRK;
        end
      end
      ST_DEC_BRK: begin
        if (confirm_alloc && !conf_s2_q) begin
          state_d = ST_FAULT;
        end else if (out_freq <= brk_on_freq_q) begin
          release_d = 1'b0;
          if (confirm_alloc) begin
            state_d = ST_CONF_OFF;
            tmr_val_d = conf_wait_q;
          end else begin
            state_d = ST_STOP_WAIT;
            tmr_val_d = stop_wait_q;
          end
        end
      end
      ST_CONF_OFF: begin
        if (!conf_s2_q) begin
          state_d = ST_STOP_WAIT;
          tmr_val_d = stop_wait_q;
        end else if (tmr_done) begin
          state_d = ST_FAULT;
        end
      end
      ST_STOP_WAIT: begin
        if (tmr_done) begin
          state_d = ST_DEC_ZERO;
        end
      end
      ST_DEC_ZERO: begin
        if (out_freq == 16'h0000) begin
          state_d = ST_IDLE;
        end
      end
      ST_FAULT: begin
        if (clear_cmd) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        release_d = 1'b0;
      end
    endcase
    release_d = release_d && (state_d != ST_FAULT); // a trip closes the brake at once
  end

  // sequence registers and drive-side outputs
  always @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      brake_release_out_q <= 1'b0;
      brake_error_out_q <= 1'b0;
      trip_q <= 1'b0;
      err_code_q <= 8'h00;
      tmr_start_q <= 1'b0;
      tmr_val_q <= 16'h0000;
      freq_limit_q <= `HBS_FREQ_NO_LIMIT;
      freq_hold_q <= 1'b0;
      term_out_q <= 2'b00;
    end else begin
      state_q <= state_d;
      brake_release_out_q <= release_d;
      tmr_val_q <= tmr_val_d;
      // a new wait starts on every entry to a wait state
      tmr_start_q <= (state_d != state_q) && ((state_d == ST_REL_WAIT) || (state_d == ST_CONF_ON) ||
                     (state_d == ST_ACC_WAIT) || (state_d == ST_CONF_OFF) || (state_d == ST_STOP_WAIT));
      if (state_d == ST_FAULT) begin
        trip_q <= 1'b1;
        brake_error_out_q <= 1'b1;
        err_code_q <= `HBS_ERR_BRAKE;
      end else begin
        trip_q <= 1'b0;
        brake_error_out_q <= 1'b0;
      end
      // frequency cap seen by the ramp; hold freezes the ramp where it is
      case (state_d)
        ST_ACC_REL, ST_REL_WAIT, ST_CONF_ON, ST_ACC_WAIT: freq_limit_q <= rel_freq_q;
        ST_DEC_BRK, ST_CONF_OFF, ST_STOP_WAIT: freq_limit_q <= brk_on_freq_q;
        ST_DEC_ZERO, ST_FAULT: freq_limit_q <= 16'h0000;
        default: freq_limit_q <= `HBS_FREQ_NO_LIMIT;
      endcase
      freq_hold_q <= (state_d == ST_REL_WAIT) || (state_d == ST_CONF_ON) || (state_d == ST_ACC_WAIT) ||
                     (state_d == ST_CONF_OFF) || (state_d == ST_STOP_WAIT);
      term_out_q[0] <= term_level(out0_func_q, release_d, state_d == ST_FAULT);
      term_out_q[1] <= term_level(out1_func_q, release_d, state_d == ST_FAULT);
    end
  end

  // settings registers; written values saturate at their limits
  always @(posedge clk_sys) begin
    if (!resetn) begin
      enable_q <= `HBS_CTRL_DISABLED;
      rel_wait_q <= 16'h0000;
      acc_wait_q <= 16'h0000;
      stop_wait_q <= 16'h0000;
      conf_wait_q <= 16'h0000;
      rel_freq_q <= 16'h0000;
      rel_cur_q <= `HBS_CUR_RESET;
      brk_on_freq_q <= 16'h0000;
      in_func_q <= 8'h00;
      out0_func_q <= 8'h00;
      out1_func_q <= 8'h00;
      irq_mask_q <= 3'b000;
    end else if (reg_wr) begin
      case (reg_addr)
        `HBS_OFS_ENABLE: enable_q <= reg_wdata[7:0];
        `HBS_OFS_REL_WAIT: rel_wait_q <= sat16(reg_wdata, `HBS_TIME_MAX);
        `HBS_OFS_ACC_WAIT: acc_wait_q <= sat16(reg_wdata, `HBS_TIME_MAX);
        `HBS_OFS_STOP_WAIT: stop_wait_q <= sat16(reg_wdata, `HBS_TIME_MAX);
        `HBS_OFS_CONF_WAIT: conf_wait_q <= sat16(reg_wdata, `HBS_TIME_MAX);
        `HBS_OFS_REL_FREQ: rel_freq_q <= sat16(reg_wdata, `HBS_FREQ_MAX);
        `HBS_OFS_REL_CUR: rel_cur_q <= sat16(reg_wdata, `HBS_CUR_MAX);
        `HBS_OFS_BRK_ON_FREQ: brk_on_freq_q <= sat16(reg_wdata, `HBS_FREQ_MAX);
        `HBS_OFS_TERM_FUNC: begin
          in_func_q <= reg_wdata[7:0];
          out0_func_q <= reg_wdata[15:8];
          out1_func_q <= reg_wdata[23:16];
        end
        `HBS_OFS_IRQ_MASK: irq_mask_q <= reg_wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // sticky events; a new event beats a write-one clear in the same cycle
  assign irq_event = {(release_d == 1'b0) && brake_release_out_q,
                      release_d && !brake_release_out_q,
                      (state_d == ST_FAULT) && (state_q != ST_FAULT)};
  assign irq_w1c = (reg_wr && (reg_addr == `HBS_OFS_IRQ_STAT)) ? reg_wdata[2:0] : 3'b000;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      irq_stat_q <= 3'b000;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_event;
      irq_q <= |(((irq_stat_q & ~irq_w1c) | irq_event) & irq_mask_q);
    end
  end

  // read data stand in the cycle after the strobe only
  always @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `HBS_OFS_ENABLE: reg_rdata_q <= {24'h00_0000, enable_q};
        `HBS_OFS_REL_WAIT: reg_rdata_q <= {16'h0000, rel_wait_q};
        `HBS_OFS_ACC_WAIT: reg_rdata_q <= {16'h0000, acc_wait_q};
        `HBS_OFS_STOP_WAIT: reg_rdata_q <= {16'h0000, stop_wait_q};
        `HBS_OFS_CONF_WAIT: reg_rdata_q <= {16'h0000, conf_wait_q};
        `HBS_OFS_REL_FREQ: reg_rdata_q <= {16'h0000, rel_freq_q};
        `HBS_OFS_REL_CUR: reg_rdata_q <= {16'h0000, rel_cur_q};
        `HBS_OFS_BRK_ON_FREQ: reg_rdata_q <= {16'h0000, brk_on_freq_q};
        `HBS_OFS_TERM_FUNC: reg_rdata_q <= {8'h00, out1_func_q, out0_func_q, in_func_q};
        `HBS_OFS_STATUS: reg_rdata_q <= {16'h0000, err_code_q, conf_s2_q, trip_q, brake_error_out_q,
                                         brake_release_out_q, state_q};
        `HBS_OFS_IRQ_STAT: reg_rdata_q <= {29'h0000_0000, irq_stat_q};
        `HBS_OFS_IRQ_MASK: reg_rdata_q <= {29'h0000_0000, irq_mask_q};
        default: reg_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

endmodule // hbs_brake_seq

// ### rtl/hbs_consts.vh
/*
  hbs_consts.vh: offsets, field positions, reset values, codes and timing
  counts of the hoist brake sequencer.
  Assumes a 25 MHz system clock and a byte-addressed plain register port.
*/
`ifndef HBS_CONSTS_VH
`define HBS_CONSTS_VH

// register byte offsets
`define HBS_OFS_ENABLE 6'h00
`define HBS_OFS_REL_WAIT 6'h04
`define HBS_OFS_ACC_WAIT 6'h08
`define HBS_OFS_STOP_WAIT 6'h0C
`define HBS_OFS_CONF_WAIT 6'h10
`define HBS_OFS_REL_FREQ 6'h14
`define HBS_OFS_REL_CUR 6'h18
`define HBS_OFS_BRK_ON_FREQ 6'h1C
`define HBS_OFS_TERM_FUNC 6'h20
`define HBS_OFS_STATUS 6'h24
`define HBS_OFS_IRQ_STAT 6'h28
`define HBS_OFS_IRQ_MASK 6'h2C
`define HBS_OFS_CMD 6'h30

// brake control selection codes
`define HBS_CTRL_DISABLED 8'h00
`define HBS_CTRL_ENABLED 8'h01

// terminal function codes
`define HBS_FUNC_CONFIRM 8'h2C
`define HBS_FUNC_RELEASE 8'h13
`define HBS_FUNC_ERROR 8'h14

// brake error code reported in status
`define HBS_ERR_BRAKE 8'h24

// limits: times in 10 ms units, frequencies in 0.01 Hz, current in 0.1 % of rated
`define HBS_TIME_MAX 16'h01F4
`define HBS_FREQ_MAX 16'h9C40
`define HBS_CUR_MAX 16'h07D0
`define HBS_CUR_RESET 16'h03E8
`define HBS_FREQ_NO_LIMIT 16'hFFFF

// status field positions
`define HBS_ST_STATE_LSB 0
`define HBS_ST_RELEASE 4
`define HBS_ST_ERROR 5
`define HBS_ST_TRIP 6
`define HBS_ST_CONFIRM 7
`define HBS_ST_CODE_LSB 8

// interrupt bit positions
`define HBS_IRQ_FAULT 0
`define HBS_IRQ_RELEASED 1
`define HBS_IRQ_ENGAGED 2

// command bit: clear a trip
`define HBS_CMD_CLEAR 0

// timer tick: period in ms and clock rate in kHz
`define HBS_TICK_MS 10
`define HBS_CLK_KHZ 25000
`define HBS_TICK_CYCLES (`HBS_TICK_MS * `HBS_CLK_KHZ)

`endif

// ### rtl/hbs_wait_timer.v
/*
  hbs_wait_timer: one wait timer counting in 10 ms ticks.
  Assumes start and abort come from logic on clk_sys; start wins over abort.
*/
`timescale 1ns/1ns
`include "hbs_consts.vh"

module hbs_wait_timer #(
  parameter [31:0] TICK_CYCLES = `HBS_TICK_CYCLES
) (
  input wire clk_sys,
  input wire resetn,
  input wire start,
  input wire abort,
  input wire [15:0] load_val,
  output reg done_q
);

  reg [31:0] pre_q;
  reg [15:0] cnt_q;
  reg run_q;

  // prescaler restarts on start so every wait is a whole number of ticks
  always @(posedge clk_sys) begin
    if (!resetn) begin
      pre_q <= 32'h0000_0000;
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else if (start) begin
      pre_q <= 32'h0000_0000;
      cnt_q <= load_val;
      run_q <= 1'b1;
      done_q <= 1'b0;
    end else if (abort) begin
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else if (run_q) begin
      if (cnt_q == 16'h0000) begin
        run_q <= 1'b0;
        done_q <= 1'b1;
      end else if (pre_q == TICK_CYCLES - 32'h0000_0001) begin
        pre_q <= 32'h0000_0000;
        cnt_q <= cnt_q - 16'h0001;
      end else begin
        pre_q <= pre_q + 32'h0000_0001;
      end
    end else begin
      done_q <= 1'b0;
    end
  end

endmodule // hbs_wait_timer

// ### sim/hbs_brake_model.sv
/* hbs_brake_model: brake with a confirmation contact.
   assumes release_in from the sequencer; mode 1/2 stick the contact. */
`timescale 1ns/1ns
module hbs_brake_model (
  input wire clk_sys,
  input wire release_in,
  input wire [1:0] mode,
  output logic confirm
);
  logic [1:0] dly_q = 2'h0;
  initial confirm = 1'b0;
  // contact lags the coil, as a real brake does
  always @(posedge clk_sys) begin
    if (mode == 2'h1) begin
      confirm <= 1'b0;
    end else if (mode == 2'h2) begin
      confirm <= 1'b1;
    end else if (confirm != release_in) begin
      dly_q <= dly_q + 2'h1;
      if (dly_q == 2'h3) confirm <= release_in;
    end else begin
      dly_q <= 2'h0;
    end
  end
endmodule // hbs_brake_model

// ### sim/hbs_brake_seq_properties.sv
/* hbs_seq_props: port-level checks of the brake sequencer.
   assumes a bind onto hbs_brake_seq, one clock, synchronous reset. */
`timescale 1ns/1ns
module hbs_seq_props #(
  parameter [31:0] TICK_CYCLES = 4
) (
  input wire clk_sys,
  input wire resetn,
  input wire reg_rd,
  input wire reg_wr,
  input wire [31:0] reg_rdata_q,
  input wire run_cmd,
  input wire [15:0] freq_limit_q,
  input wire trip_q,
  input wire brake_release_out_q,
  input wire brake_error_out_q,
  input wire [1:0] term_out_q,
  input wire irq_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // read data may only follow a read strobe
  rd_idle_a: assert property (reg_rdata_q != 0 |-> $past(reg_rd))
    else $error("read data without strobe");
  error_trip_a: assert property (brake_error_out_q == trip_q)
    else $error("error flag differs from trip");
  trip_safe_a: assert property (trip_q |-> !brake_release_out_q && freq_limit_q == 0)
    else $error("brake open or limit set in fault");
  trip_exit_a: assert property ($fell(trip_q) |-> reg_wr || $past(reg_wr))
    else $error("trip left without clear");
  // no free acceleration right after the release
  accel_wait_a: assert property ($rose(brake_release_out_q) |->
    freq_limit_q != 16'hFFFF ##1 freq_limit_q != 16'hFFFF)
    else $error("acceleration freed too early");
  release_run_a: assert property ($rose(brake_release_out_q) |-> $past(run_cmd))
    else $error("release without run");
  stop_wait_a: assert property ($fell(brake_release_out_q) && !trip_q |-> freq_limit_q != 0 [*2])
    else $error("decel to zero without stop wait");
  term_src_a: assert property (term_out_q != 0 |-> brake_release_out_q || brake_error_out_q
    || $past(brake_release_out_q) || $past(brake_error_out_q))
    else $error("terminal set without source");
  // a mask write shows on the interrupt two edges after its strobe
  irq_src_a: assert property ($rose(irq_q) |-> reg_wr || $past(reg_wr) || $past(reg_wr, 2)
    || $rose(trip_q) || $changed(brake_release_out_q))
    else $error("interrupt without event");
  release_c: cover property ($rose(brake_release_out_q));
  engage_c: cover property ($fell(brake_release_out_q) && !trip_q);
  fault_c: cover property ($rose(trip_q));
endmodule // hbs_seq_props

// ### sim/hoist_brake_sequencer_bench.sv
/* hoist_brake_sequencer_bench: drives run, ramp and registers of the sequencer.
   assumes the brake model on the contact and a short timer tick. */
`timescale 1ns/1ns
module hoist_brake_sequencer_bench;
  logic clk_sys = 0;
  logic resetn = 0;
  logic [5:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic run_cmd = 0;
  logic [15:0] out_freq = 0;
  logic [15:0] out_current = 16'h05DC;
  logic [1:0] mode = 0;
  wire brake_confirm_in, freq_hold_q, trip_q, brake_release_out_q, brake_error_out_q, irq_q;
  wire [31:0] reg_rdata_q;
  wire [15:0] freq_limit_q, goal;
  wire [1:0] term_out_q;
  int bad_count = 0;
  int samples_checked = 0;
  int n;
  logic [31:0] d;
  typedef struct packed {logic [5:0] a; logic [31:0] w; logic [31:0] e;} hbs_row_t;
  hbs_row_t rows [14] = '{'{6'h18, 32'h0000_0BB8, 32'h0000_07D0}, '{6'h04, 32'h0000_0258, 32'h0000_01F4},
    '{6'h14, 32'h0000_C350, 32'h0000_9C40}, '{6'h3C, 32'h5, 32'h0}, '{6'h24, 32'h0000_FFFF, 32'h0},
    '{6'h04, 32'h2, 32'h2}, '{6'h08, 32'h2, 32'h2}, '{6'h0C, 32'h2, 32'h2}, '{6'h10, 32'h5, 32'h5},
    '{6'h14, 32'h0000_07D0, 32'h0000_07D0}, '{6'h1C, 32'h0000_03E8, 32'h0000_03E8},
    '{6'h18, 32'h0000_03E8, 32'h0000_03E8}, '{6'h20, 32'h0014_132C, 32'h0014_132C}, '{6'h2C, 32'h7, 32'h7}};
  always #20 clk_sys = ~clk_sys;
  hbs_brake_seq #(.TICK_CYCLES(4)) uut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .run_cmd, .out_freq, .out_current, .brake_confirm_in, .freq_limit_q, .freq_hold_q,
    .trip_q, .brake_release_out_q, .brake_error_out_q, .term_out_q, .irq_q);
  hbs_brake_model brake_release_out (.clk_sys, .release_in(brake_release_out_q), .mode, .confirm(brake_confirm_in));
  // drive ramp: 1 Hz a cycle toward run target, capped, frozen on hold
  assign goal = !run_cmd ? 16'h0 : (freq_limit_q < 16'h2710 ? freq_limit_q : 16'h2710);
  always @(posedge clk_sys) begin
    if (!freq_hold_q) begin
      out_freq <= out_freq < goal ? out_freq + 16'h64 : (out_freq > goal ? out_freq - 16'h64 : out_freq);
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] w);
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk_sys);
    reg_wr <= 0;
    #1;
  endtask
  task rd(input logic [5:0] a);
    @(posedge clk_sys);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 d = reg_rdata_q;
  endtask
  function automatic bit cond(input int k);
    case (k)
      0: return brake_release_out_q === 1'b1;
      1: return brake_release_out_q === 1'b0;
      2: return trip_q === 1'b1;
      3: return out_freq == 16'h2710;
      4: return out_freq == 16'h0;
      default: return out_freq == 16'h07D0;
    endcase
  endfunction
  task results;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // bounded wait; n gives the cycles it took
  task wt(input int k, input int lim);
    n = 0;
    while (!cond(k) && n < lim) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (!cond(k)) begin
      bad_count++;
      $display("Error at %0t: wait %0d ran out", $time, k);
      results;
    end
  endtask
  task go(input logic [1:0] m, input logic [15:0] cur);
    @(posedge clk_sys);
    mode <= m;
    out_current <= cur;
    run_cmd <= 1;
  endtask
  task clr;
    @(posedge clk_sys);
    run_cmd <= 0;
    wr(6'h30, 32'h1);
    wt(4, 400);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1;
    #1 chk({freq_hold_q, trip_q, brake_release_out_q, brake_error_out_q, term_out_q, irq_q, freq_limit_q},
      32'h0000_FFFF);
    rd(6'h18);
    chk(d, 32'h0000_03E8);
    rd(6'h00);
    chk(d, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(d, rows[i].e);
    end
    // bypass while disabled
    go(0, 16'h05DC);
    wt(3, 400);
    chk(brake_release_out_q, 0);
    @(posedge clk_sys);
    run_cmd <= 0;
    wt(4, 400);
    // whole sequence with the contact allocated
    wr(6'h00, 32'h1);
    go(0, 16'h05DC);
    wt(5, 400);
    wt(0, 100);
    chk(out_freq, 16'h07D0);
    chk(n >= 8 && n <= 14, 1);
    chk({term_out_q, irq_q}, 3'b011);
    wr(6'h28, 32'h2);
    rd(6'h28);
    chk({d[2:0], irq_q}, 4'b0000);
    wt(3, 400);
    rd(6'h24);
    chk(d, 32'h0000_0095);
    @(posedge clk_sys);
    run_cmd <= 0;
    wt(1, 400);
    chk(out_freq <= 16'h03E8 && out_freq >= 16'h0384, 1);
    d = out_freq;
    repeat (6) @(posedge clk_sys);
    #1 chk(out_freq, d);
    wt(4, 400);
    rd(6'h24);
    chk(d, 32'h0);
    // contact not allocated: no confirmation wait
    wr(6'h20, 32'h0014_1300);
    go(1, 16'h05DC);
    wt(3, 400);
    @(posedge clk_sys);
    run_cmd <= 0;
    wt(4, 400);
    wr(6'h20, 32'h0014_132C);
    wr(6'h2C, 32'h0);
    wr(6'h28, 32'h7);
    // current too low when release wait ends; masked interrupt
    go(0, 16'h01F4);
    wt(2, 400);
    chk({brake_release_out_q, term_out_q, irq_q}, 4'b0100);
    rd(6'h24);
    chk(d, 32'h0000_246A);
    wr(6'h2C, 32'h1);
    rd(6'h28);
    chk({d[2:0], irq_q}, 4'b0011);
    wr(6'h28, 32'h1);
    rd(6'h28);
    chk({d[2:0], irq_q}, 4'b0000);
    clr;
    chk(trip_q, 0);
    // confirmation never arrives
    go(1, 16'h05DC);
    wt(0, 100);
    wt(2, 100);
    chk(n >= 20 && n <= 26, 1);
    clr;
    // confirmation lost while running
    go(0, 16'h05DC);
    wt(3, 400);
    @(posedge clk_sys);
    mode <= 1;
    wt(2, 20);
    clr;
    // contact stays open after the brake is set
    go(0, 16'h05DC);
    wt(3, 400);
    @(posedge clk_sys);
    mode <= 2;
    run_cmd <= 0;
    wt(1, 400);
    wt(2, 100);
    chk(n >= 20 && n <= 26, 1);
    // reset while tripped: trip, error code and enable code return to defaults
    @(posedge clk_sys);
    resetn <= 0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1;
    #1 chk({trip_q, brake_error_out_q, brake_release_out_q, irq_q, freq_limit_q}, 32'h0000_FFFF);
    rd(6'h24);
    chk(d, 32'h0);
    rd(6'h00);
    chk(d, 32'h0);
    results;
  end
endmodule // hoist_brake_sequencer_bench
bind hbs_brake_seq hbs_seq_props #(.TICK_CYCLES(TICK_CYCLES)) props (.clk_sys, .resetn, .reg_rd, .reg_wr,
  .reg_rdata_q, .run_cmd, .freq_limit_q, .trip_q, .brake_release_out_q, .brake_error_out_q, .term_out_q, .irq_q);
